// ===== rtl/rfcr_config_regs.sv
// Contract
// - Gain code maps to 18/23/33/38/43/48 dB.
// - N-driver upper nibble is carrier conductance.
// - N-driver lower nibble sets modulation index.
// - N-driver values used only when driver on.
// - P-driver carrier field bits 5..0; 7..6 reserved.
// - P-driver modulation field ignored under full ASK.
// - Soft power-down forces every conductance MSB high, except values zeroed by full ASK or drivers off.
// - Twelve-bit divider: four mode bits, eight lower.
// - Auto-start starts timer at transmission end.
// - Gate field selects none, frame, auxiliary, undefined.
// - Auto-reload reloads at zero, else stops, flags.
// - Timer divides by 2P+1 or 2P+2.
//
// The APB register port is this design's own decision.
module rfcr_config_regs
  import rfcr_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  rfcr_apb_req_t               apb_req,
  output logic [RFCR_DATA_W-1:0]      prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   tx_end,
  input  wire logic                   timer_at_zero,
  input  wire logic                   frame_input_pin,
  input  wire logic                   auxiliary_pin_one,
  output rfcr_drive_t                 drive,
  output logic [5:0]                  receiver_gain_db,
  output rfcr_timer_cfg_t             timer_cfg,
  output logic [12:0]                 timer_divisor,
  output logic                        timer_start,
  output logic                        timer_gate_open,
  output logic                        timer_reload,
  output logic                        timer_halt,
  output logic                        timer_irq_flag
);

  // Register indices must be reachable through the byte address.
  if (ADDR_W < RFCR_MIN_ADDR_W || ADDR_W > RFCR_DATA_W) begin : g_bad_addr_w
    $error("ADDR_W must lie between 8 and 32");
  end

  logic [7:0] receiver_gain_config;
  logic [7:0] n_driver_conductance;
  logic [7:0] p_driver_carrier_conductance;
  logic [7:0] p_driver_modulation_conductance;
  logic [7:0] timer_mode_config;
  logic [7:0] timer_divider_lower;
  logic [7:0] driver_control;

  logic [ADDR_W-1:0]      word_index;
  logic                   hit_gain;
  logic                   hit_ncond;
  logic                   hit_pcw;
  logic                   hit_pmod;
  logic                   hit_tmode;
  logic                   hit_tdiv;
  logic                   hit_ctrl;
  logic                   hit_status;
  logic                   addr_ok;
  logic                   setup_phase;
  logic                   wr_commit;
  logic [7:0]             wbyte;
  logic [RFCR_DATA_W-1:0] next_prdata;
  logic [RFCR_DATA_W-1:0] status_word;

  logic [1:0] frame_sync;
  logic [1:0] aux_sync;

  rfcr_drive_t next_drive;
  logic [5:0]  next_gain_db;
  logic [11:0] divider;
  logic [12:0] next_divisor;
  rfcr_gate_t  gate_sel;
  logic        next_gate_open;

  // Address decode.
  assign word_index = paddr >> 2;
  assign hit_gain   = word_index == ADDR_W'(RFCR_IDX_GAIN);
  assign hit_ncond  = word_index == ADDR_W'(RFCR_IDX_NCOND);
  assign hit_pcw    = word_index == ADDR_W'(RFCR_IDX_PCW);
  assign hit_pmod   = word_index == ADDR_W'(RFCR_IDX_PMOD);
  assign hit_tmode  = word_index == ADDR_W'(RFCR_IDX_TMODE);
  assign hit_tdiv   = word_index == ADDR_W'(RFCR_IDX_TDIV_LO);
  assign hit_ctrl   = word_index == ADDR_W'(RFCR_IDX_CTRL);
  assign hit_status = word_index == ADDR_W'(RFCR_IDX_STATUS);
  assign addr_ok    = hit_gain | hit_ncond | hit_pcw | hit_pmod | hit_tmode
                    | hit_tdiv | hit_ctrl | hit_status;

  assign setup_phase = psel & ~penable;
  // Only the low byte lane carries register data; other lanes are ignored.
  assign wr_commit = psel & penable & pready & apb_req.pwrite
                   & apb_req.pstrb[0] & addr_ok;
  assign wbyte = apb_req.pwdata[7:0];

  // No wait states: the answer is prepared during the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_phase & ~addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase) begin
      prdata <= next_prdata;
    end else if (pready) begin
      prdata <= '0;
    end
  end

  assign status_word = {
    next_gate_open,
    drive.enable,
    receiver_gain_db,
    2'b00,
    drive.p_drv_mod_conductance,
    2'b00,
    drive.p_drv_carrier_conductance,
    drive.n_drv_carrier_conductance,
    drive.n_drv_mod_conductance
  };

  always_comb begin
    next_prdata = '0;
    if (!apb_req.pwrite) begin
      unique case (1'b1)
        hit_gain:   next_prdata[7:0] = receiver_gain_config & RFCR_MASK_GAIN;
        hit_ncond:  next_prdata[7:0] = n_driver_conductance;
        hit_pcw:    next_prdata[7:0] = p_driver_carrier_conductance & RFCR_MASK_P;
        hit_pmod:   next_prdata[7:0] = p_driver_modulation_conductance & RFCR_MASK_P;
        hit_tmode:  next_prdata[7:0] = timer_mode_config;
        hit_tdiv:   next_prdata[7:0] = timer_divider_lower;
        hit_ctrl:   next_prdata[7:0] = driver_control & RFCR_MASK_CTRL;
        hit_status: next_prdata = status_word;
        default:    next_prdata = '0;
      endcase
    end
  end

  // Reserved bits keep their reset pattern and never take written data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receiver_gain_config <= RFCR_RST_GAIN;
    end else if (wr_commit && hit_gain) begin
      receiver_gain_config <= (receiver_gain_config & ~RFCR_MASK_GAIN)
                            | (wbyte & RFCR_MASK_GAIN);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_driver_conductance <= RFCR_RST_NCOND;
    end else if (wr_commit && hit_ncond) begin
      n_driver_conductance <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_driver_carrier_conductance <= RFCR_RST_PCW;
    end else if (wr_commit && hit_pcw) begin
      p_driver_carrier_conductance <= wbyte & RFCR_MASK_P;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_driver_modulation_conductance <= RFCR_RST_PMOD;
    end else if (wr_commit && hit_pmod) begin
      p_driver_modulation_conductance <= wbyte & RFCR_MASK_P;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_config <= RFCR_RST_TMODE;
    end else if (wr_commit && hit_tmode) begin
      timer_mode_config <= wbyte & RFCR_MASK_FULL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_divider_lower <= RFCR_RST_TDIV_LO;
    end else if (wr_commit && hit_tdiv) begin
      timer_divider_lower <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      driver_control <= RFCR_RST_CTRL;
    end else if (wr_commit && hit_ctrl) begin
      driver_control <= wbyte & RFCR_MASK_CTRL;
    end
  end

  rfcr_drive_shaper u_shaper (
    .n_driver_conductance            (n_driver_conductance),
    .p_driver_carrier_conductance    (p_driver_carrier_conductance),
    .p_driver_modulation_conductance (p_driver_modulation_conductance),
    .soft_power_down                 (driver_control[RFCR_CTRL_PD]),
    .antenna_driver_a                (driver_control[RFCR_CTRL_DRVA]),
    .antenna_driver_b                (driver_control[RFCR_CTRL_DRVB]),
    .forced_full_depth_ask           (driver_control[RFCR_CTRL_ASK]),
    .drive                           (next_drive)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '0;
    end else begin
      drive <= next_drive;
    end
  end

  always_comb begin
    unique case (receiver_gain_config[RFCR_GAIN_LSB +: 3])
      3'h0, 3'h2: next_gain_db = RFCR_DB_18;
      3'h1, 3'h3: next_gain_db = RFCR_DB_23;
      3'h4:       next_gain_db = RFCR_DB_33;
      3'h5:       next_gain_db = RFCR_DB_38;
      3'h6:       next_gain_db = RFCR_DB_43;
      3'h7:       next_gain_db = RFCR_DB_48;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receiver_gain_db <= RFCR_DB_33;
    end else begin
      receiver_gain_db <= next_gain_db;
    end
  end

  assign divider = {timer_mode_config[3:0], timer_divider_lower};
  assign gate_sel = rfcr_gate_t'(timer_mode_config[RFCR_TGATE_LSB +: 2]);

  // The 13.56 MHz reference is divided by 2P+1, or 2P+2 when even.
  always_comb begin
    next_divisor = {divider, 1'b0} + 13'h0001;
    if (driver_control[RFCR_CTRL_EVEN]) begin
      next_divisor = {divider, 1'b0} + 13'h0002;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_divisor <= 13'h0001;
    end else begin
      timer_divisor <= next_divisor;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_cfg <= '0;
    end else begin
      timer_cfg.timer_auto_start  <= timer_mode_config[RFCR_TIMER_AUTO_START_BIT];
      timer_cfg.timer_gate_select <= gate_sel;
      timer_cfg.timer_auto_reload <= timer_mode_config[RFCR_TRLD_BIT];
      timer_cfg.divider           <= divider;
      timer_cfg.timer_even_divide <= driver_control[RFCR_CTRL_EVEN];
    end
  end

  // Gate pins are asynchronous to pclk.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_sync <= 2'b00;
      aux_sync   <= 2'b00;
    end else begin
      frame_sync <= {frame_sync[0], frame_input_pin};
      aux_sync   <= {aux_sync[0], auxiliary_pin_one};
    end
  end

  // The undefined gate code keeps the timer closed rather than guessing.
  always_comb begin
    unique case (gate_sel)
      RFCR_GATE_NONE:  next_gate_open = 1'b1;
      RFCR_GATE_FRAME: next_gate_open = frame_sync[1];
      RFCR_GATE_AUX:   next_gate_open = aux_sync[1];
      RFCR_GATE_UNDEF: next_gate_open = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_gate_open <= 1'b0;
    end else begin
      timer_gate_open <= next_gate_open;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_start <= 1'b0;
    end else begin
      timer_start <= tx_end & timer_mode_config[RFCR_TIMER_AUTO_START_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_reload <= 1'b0;
    end else begin
      timer_reload <= timer_at_zero & timer_mode_config[RFCR_TRLD_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_halt <= 1'b0;
    end else begin
      timer_halt <= timer_at_zero & ~timer_mode_config[RFCR_TRLD_BIT];
    end
  end

  // The flag follows timer_at_zero one cycle later while auto-reload is off and is not held; holding and clearing it is left to the interrupt logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq_flag <= 1'b0;
    end else begin
      timer_irq_flag <= timer_at_zero & ~timer_mode_config[RFCR_TRLD_BIT];
    end
  end

endmodule

// ===== rtl/rfcr_pkg.sv
package rfcr_pkg;

  localparam int unsigned RFCR_DATA_W = 32;
  localparam int unsigned RFCR_MIN_ADDR_W = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] RFCR_IDX_GAIN    = 6'h26;
  localparam logic [5:0] RFCR_IDX_NCOND   = 6'h27;
  localparam logic [5:0] RFCR_IDX_PCW     = 6'h28;
  localparam logic [5:0] RFCR_IDX_PMOD    = 6'h29;
  localparam logic [5:0] RFCR_IDX_TMODE   = 6'h2a;
  localparam logic [5:0] RFCR_IDX_TDIV_LO = 6'h2b;
  localparam logic [5:0] RFCR_IDX_CTRL    = 6'h30;
  localparam logic [5:0] RFCR_IDX_STATUS  = 6'h31;

  localparam logic [7:0] RFCR_RST_GAIN    = 8'h48;
  localparam logic [7:0] RFCR_RST_NCOND   = 8'h88;
  localparam logic [7:0] RFCR_RST_PCW     = 8'h20;
  localparam logic [7:0] RFCR_RST_PMOD    = 8'h20;
  localparam logic [7:0] RFCR_RST_TMODE   = 8'h00;
  localparam logic [7:0] RFCR_RST_TDIV_LO = 8'h00;
  localparam logic [7:0] RFCR_RST_CTRL    = 8'h00;

  // Writable bits; everything else is reserved and reads as zero.
  localparam logic [7:0] RFCR_MASK_GAIN   = 8'h70;
  localparam logic [7:0] RFCR_MASK_FULL   = 8'hff;
  localparam logic [7:0] RFCR_MASK_P      = 8'h3f;
  localparam logic [7:0] RFCR_MASK_CTRL   = 8'h1f;

  localparam int unsigned RFCR_GAIN_LSB   = 4;
  localparam int unsigned RFCR_TIMER_AUTO_START_BIT  = 7;
  localparam int unsigned RFCR_TGATE_LSB  = 5;
  localparam int unsigned RFCR_TRLD_BIT   = 4;
  localparam int unsigned RFCR_CTRL_PD    = 0;
  localparam int unsigned RFCR_CTRL_DRVA  = 1;
  localparam int unsigned RFCR_CTRL_DRVB  = 2;
  localparam int unsigned RFCR_CTRL_ASK   = 3;
  localparam int unsigned RFCR_CTRL_EVEN  = 4;

  localparam logic [5:0] RFCR_DB_18 = 6'h12;
  localparam logic [5:0] RFCR_DB_23 = 6'h17;
  localparam logic [5:0] RFCR_DB_33 = 6'h21;
  localparam logic [5:0] RFCR_DB_38 = 6'h26;
  localparam logic [5:0] RFCR_DB_43 = 6'h2b;
  localparam logic [5:0] RFCR_DB_48 = 6'h30;

  typedef enum logic [1:0] {
    RFCR_GATE_NONE,
    RFCR_GATE_FRAME,
    RFCR_GATE_AUX,
    RFCR_GATE_UNDEF
  } rfcr_gate_t;

  typedef struct packed {
    logic                   pwrite;
    logic [RFCR_DATA_W-1:0] pwdata;
    logic [3:0]             pstrb;
  } rfcr_apb_req_t;

  typedef struct packed {
    logic       enable;
    logic [3:0] n_drv_carrier_conductance;
    logic [3:0] n_drv_mod_conductance;
    logic [5:0] p_drv_carrier_conductance;
    logic [5:0] p_drv_mod_conductance;
  } rfcr_drive_t;

  typedef struct packed {
    logic       timer_auto_start;
    rfcr_gate_t timer_gate_select;
    logic       timer_auto_reload;
    logic [11:0] divider;
    logic       timer_even_divide;
  } rfcr_timer_cfg_t;

endpackage

// ===== rtl/rfcr_drive_shaper.sv
module rfcr_drive_shaper
  import rfcr_pkg::*;
(
  input  wire logic [7:0] n_driver_conductance,
  input  wire logic [7:0] p_driver_carrier_conductance,
  input  wire logic [7:0] p_driver_modulation_conductance,
  input  wire logic       soft_power_down,
  input  wire logic       antenna_driver_a,
  input  wire logic       antenna_driver_b,
  input  wire logic       forced_full_depth_ask,
  output rfcr_drive_t     drive
);

  logic [3:0] n_cw;
  logic [3:0] n_mod;
  logic [5:0] p_cw;
  logic [5:0] p_mod;

  always_comb begin
    n_cw  = n_driver_conductance[7:4];
    n_mod = n_driver_conductance[3:0];
    p_cw  = p_driver_carrier_conductance[5:0];
    p_mod = p_driver_modulation_conductance[5:0];
    if (soft_power_down) begin
      n_cw[3]  = 1'b1;
      n_mod[3] = 1'b1;
      p_cw[5]  = 1'b1;
      p_mod[5] = 1'b1;
    end
    // Full-depth keying switches the p-driver off while modulating.
    if (forced_full_depth_ask) begin
      p_mod = 6'h00;
    end
    drive.enable = antenna_driver_a | antenna_driver_b;
    drive.n_drv_carrier_conductance = drive.enable ? n_cw : 4'h0;
    drive.n_drv_mod_conductance     = drive.enable ? n_mod : 4'h0;
    drive.p_drv_carrier_conductance = p_cw;
    drive.p_drv_mod_conductance     = p_mod;
  end

endmodule

// ===== sim/rfcr_config_regs_chk.sv
module rfcr_config_regs_chk
  import rfcr_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
)(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [ADDR_W-1:0]      paddr,
  input rfcr_apb_req_t               apb_req,
  input wire logic [RFCR_DATA_W-1:0] prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   tx_end,
  input wire logic                   timer_at_zero,
  input wire logic                   frame_input_pin,
  input wire logic                   auxiliary_pin_one,
  input rfcr_drive_t                 drive,
  input wire logic [5:0]             receiver_gain_db,
  input rfcr_timer_cfg_t             timer_cfg,
  input wire logic [12:0]            timer_divisor,
  input wire logic                   timer_start,
  input wire logic                   timer_gate_open,
  input wire logic                   timer_reload,
  input wire logic                   timer_halt,
  input wire logic                   timer_irq_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  function automatic logic [5:0] db(input logic [2:0] c);
    return c[2] ? (c[1] ? (c[0] ? 6'h30 : 6'h2b) : (c[0] ? 6'h26 : 6'h21))
                : (c[0] ? 6'h17 : 6'h12);
  endfunction
  logic mapped;
  assign mapped = 32'(paddr) inside {32'h98, 32'h9c, 32'ha0, 32'ha4, 32'ha8, 32'hac,
                                     32'hc0, 32'hc4};
  // The registered timer settings already lag the mode register by the same edge as the pulses.
  a_start_on_end: assert property (
      timer_start == ($past(tx_end) && timer_cfg.timer_auto_start))
    else $error("timer start pulse does not follow end of transmission");
  a_reload_at_zero: assert property (
      timer_reload == ($past(timer_at_zero) && timer_cfg.timer_auto_reload))
    else $error("reload pulse mismatch");
  a_halt_and_flag: assert property (
      $rose(timer_at_zero) ##1 !timer_cfg.timer_auto_reload |-> timer_halt && timer_irq_flag)
    else $error("halt or flag missing at zero");
  a_divisor_value: assert property (
      $stable(timer_cfg) |-> timer_divisor == 13'({timer_cfg.divider, 1'b1})
                                             + 13'(timer_cfg.timer_even_divide))
    else $error("timer divisor wrong");
  a_gain_decode: assert property (
      pready && !apb_req.pwrite && 32'(paddr) == 32'h98
      |-> receiver_gain_db == db(prdata[6:4]) && (prdata[7:0] & 8'h8f) == 8'h0)
    else $error("gain decode or reserved gain bits wrong");
  a_reserved_zero: assert property (
      pready && !pslverr && 32'(paddr) != 32'hc4 |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_p_reserved: assert property (
      pready && 32'(paddr) inside {32'ha0, 32'ha4} |-> prdata[7:6] == 2'b00)
    else $error("p-driver reserved bits not zero");
  a_n_off_zero: assert property (
      !drive.enable |-> drive.n_drv_carrier_conductance == 4'h0
                        && drive.n_drv_mod_conductance == 4'h0)
    else $error("n-driver values used while drivers off");
  a_unmapped_err: assert property (
      pready |-> pslverr == !mapped && (!pslverr || prdata == 32'h0))
    else $error("error response wrong");
  c_start: cover property (timer_start);
  c_reload: cover property (timer_reload);
  c_error: cover property (pready && pslverr);
endmodule

// ===== sim/tb_top.sv
module tb_top
  import rfcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic [7:0]      paddr = 8'h0;
  rfcr_apb_req_t   apb_req = '0;
  logic [31:0]     prdata;
  logic            pready, pslverr, tx_end = 1'b0, at_zero = 1'b0, frame_pin = 1'b0, aux_pin = 1'b0;
  rfcr_drive_t     drive;
  logic [5:0]      gain_db;
  rfcr_timer_cfg_t tcfg;
  logic [12:0]     tdiv;
  logic            t_start, gate_open, t_reload, t_halt, t_irq;
  logic [31:0]     rdat;
  logic            rerr;
  int              fails = 0;
  int              n_compared = 0;
  rfcr_config_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_end(tx_end), .timer_at_zero(at_zero), .frame_input_pin(frame_pin),
    .auxiliary_pin_one(aux_pin), .drive(drive), .receiver_gain_db(gain_db), .timer_cfg(tcfg),
    .timer_divisor(tdiv), .timer_start(t_start), .timer_gate_open(gate_open),
    .timer_reload(t_reload), .timer_halt(t_halt), .timer_irq_flag(t_irq));
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // The request is held until pready is sampled high; the slave's latency is not assumed.
  task automatic xfer(input logic [5:0] idx, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {idx, 2'b00};
    apb_req <= '{pwrite: w, pwdata: d, pstrb: 4'hf};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, {24'hffffff, d});
  endtask
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask
  logic [5:0] ix [6] = '{RFCR_IDX_GAIN, RFCR_IDX_NCOND, RFCR_IDX_PCW, RFCR_IDX_PMOD,
                         RFCR_IDX_TMODE, RFCR_IDX_TDIV_LO};
  // Gain reset 0x48 reads as 0x40: its reserved bit 3 reads zero.
  logic [7:0] rv [6] = '{8'h40, 8'h88, 8'h20, 8'h20, 8'h00, 8'h00};
  logic [7:0] mk [6] = '{8'h70, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'hff};
  logic [5:0] dbt [8] = '{6'h12, 6'h17, 6'h12, 6'h17, 6'h21, 6'h26, 6'h2b, 6'h30};
  // Control value, then expected enable, n carrier, n modulation, p carrier, p modulation.
  logic [7:0]  cv [6] = '{8'h00, 8'h02, 8'h04, 8'h0a, 8'h03, 8'h01};
  logic [20:0] dv [6] = '{{1'b0, 4'h0, 4'h0, 6'h15, 6'h0b}, {1'b1, 4'h5, 4'h2, 6'h15, 6'h0b},
                          {1'b1, 4'h5, 4'h2, 6'h15, 6'h0b}, {1'b1, 4'h5, 4'h2, 6'h15, 6'h00},
                          {1'b1, 4'hd, 4'ha, 6'h35, 6'h2b}, {1'b0, 4'h0, 4'h0, 6'h35, 6'h2b}};
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      xfer(ix[i], 1'b0, 32'h0);
      chk(rdat, 32'(rv[i]));
    end
    for (int i = 0; i < 6; i++) begin
      wr(ix[i], 8'hff);
      xfer(ix[i], 1'b0, 32'h0);
      chk(rdat, 32'(mk[i]));
    end
    wr(6'h00, 8'hff);
    chk(32'(rerr), 32'h1);
    xfer(6'h00, 1'b0, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
    for (int c = 0; c < 8; c++) begin
      wr(RFCR_IDX_GAIN, 8'(c << 4));
      settle();
      chk(32'(gain_db), 32'(dbt[c]));
    end
    // A modulation nibble with its top bit clear shows the power-down force.
    wr(RFCR_IDX_NCOND, 8'h52);
    wr(RFCR_IDX_PCW, 8'h15);
    wr(RFCR_IDX_PMOD, 8'h0b);
    for (int i = 0; i < 6; i++) begin
      wr(RFCR_IDX_CTRL, cv[i]);
      settle();
      chk(32'(drive), 32'(dv[i]));
    end
    // Gate code 11 is left from the all-ones write, so the gate bit reads closed.
    xfer(RFCR_IDX_STATUS, 1'b0, 32'h0);
    chk(rdat, 32'h302b3500);
    wr(RFCR_IDX_TMODE, 8'h0b);
    wr(RFCR_IDX_TDIV_LO, 8'h3c);
    wr(RFCR_IDX_CTRL, 8'h00);
    settle();
    chk(32'(tcfg.divider), 32'hb3c);
    chk(32'(tdiv), 32'h1679);
    wr(RFCR_IDX_CTRL, 8'h10);
    settle();
    chk(32'(tdiv), 32'h167a);
    chk(32'(tcfg.timer_even_divide), 32'h1);
    for (int a = 0; a < 2; a++) begin
      wr(RFCR_IDX_TMODE, a ? 8'h90 : 8'h00);
      settle();
      chk(32'({tcfg.timer_auto_start, tcfg.timer_auto_reload}), a ? 32'h3 : 32'h0);
      tx_end <= 1'b1;
      at_zero <= 1'b1;
      @(posedge pclk);
      tx_end <= 1'b0;
      at_zero <= 1'b0;
      @(posedge pclk);
      chk(32'({t_start, t_reload, t_halt, t_irq}), a ? 32'hc : 32'h3);
    end
    for (int g = 0; g < 4; g++) begin
      wr(RFCR_IDX_TMODE, 8'(g << 5));
      for (int p = 0; p < 4; p++) begin
        frame_pin <= p[0];
        aux_pin <= p[1];
        repeat (5) @(posedge pclk);
        chk(32'(tcfg.timer_gate_select), 32'(g));
        chk(32'(gate_open), (g == 0) ? 32'h1 : (g == 3) ? 32'h0 : 32'(p[g - 1]));
      end
    end
    test_done();
  end
  initial begin
    #(25 * 6000);
    fails++;
    test_done();
  end
endmodule
bind rfcr_config_regs rfcr_config_regs_chk #(.ADDR_W(ADDR_W)) chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .apb_req(apb_req),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_end(tx_end),
  .timer_at_zero(timer_at_zero), .frame_input_pin(frame_input_pin),
  .auxiliary_pin_one(auxiliary_pin_one), .drive(drive), .receiver_gain_db(receiver_gain_db),
  .timer_cfg(timer_cfg), .timer_divisor(timer_divisor), .timer_start(timer_start),
  .timer_gate_open(timer_gate_open), .timer_reload(timer_reload), .timer_halt(timer_halt),
  .timer_irq_flag(timer_irq_flag));
